// *** hdl/sbtc_pkg.sv ***
// shared constants for the sixteen bit timer counter
package sbtc_pkg;
	localparam int COUNT_W = 16;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYSTEM = 2'h1;
	localparam logic [1:0] CS_EXTERNAL = 2'h2;
	localparam logic [1:0] CS_RESERVED = 2'h3;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam int PRESCALE_W = 3;
	localparam logic [2:0] PRESCALE_RESET = 3'h0;
	typedef enum logic [2:0] {
		SBTC_ARM_IDLE = 3'b001,
		SBTC_ARM_WAIT_LOW = 3'b010,
		SBTC_ARM_READY = 3'b100
	} sbtc_arm_t;
endpackage : sbtc_pkg

// *** hdl/sbtc_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ns
module sbtc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync;

	initial begin
		if (WIDTH < 1) $error("sbtc_sync width must be at least one");
	end

	// first stage feeds only the second stage
	always_comb begin
		next_stage1 = i_async;
		next_sync = stage1;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stage1 <= '0;
			o_sync <= '0;
		end else begin
			stage1 <= next_stage1;
			o_sync <= next_sync;
		end
	end
endmodule : sbtc_sync

// *** hdl/sbtc_timer.sv ***
// sixteen bit timer counter with prescaler, gate and overflow flag
//
// Functional notes
// - 16-bit up counter, high and low byte writes update it at once
// - instruction clock source advances once per instruction cycle via prescaler
// - external source counts rising pin edges, synchronised or asynchronous
// - run 0 means off; run 1 gate-enable 0 always counts; both 1 gated
// - select 00 instruction, 01 system, 10 pin or oscillator, 11 reserved
// - system clock source counts four per instruction cycle
// - prescale field divides chosen clock by 1, 2, 4 or 8
// - prescale counter hidden, cleared on any counter byte write
// - counter mode needs a falling edge before first counted rising edge
// - oscillator enable starts crystal oscillator, kept running in sleep
// - overflow may wake processor only in asynchronous external mode
// - running count is the capture compare time base
// - counter wraps all-ones to zero and sets sticky overflow flag
// - gated counting only while gate level equals gate polarity
// - sync disable lets the external clock count in sleep; the pin still passes the synchroniser
`timescale 1ns/1ns
module sbtc_timer #(
	parameter int COUNT_WIDTH = 16
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_run_bit,
	input  wire logic        i_gate_enable_bit,
	input  wire logic        i_gate_polarity_bit,
	input  wire logic [1:0]  i_clock_select_field,
	input  wire logic        i_oscillator_enable_bit,
	input  wire logic [1:0]  i_prescale_field,
	input  wire logic        i_sync_disable_bit,
	input  wire logic        i_sleep,
	input  wire logic        i_count_high_byte_we,
	input  wire logic        i_count_low_byte_we,
	input  wire logic [7:0]  i_write_data,
	input  wire logic        i_overflow_clear,
	input  wire logic        i_external_clock_pin,
	input  wire logic        i_crystal_input_pin,
	input  wire logic        i_gate_pin,
	output logic             o_crystal_output_pin,
	output logic [7:0]       o_count_high_byte,
	output logic [7:0]       o_count_low_byte,
	output logic [15:0]      o_time_base,
	output logic             o_overflow_flag,
	output logic             o_wake,
	output logic             o_oscillator_running
);
	initial begin
		if (COUNT_WIDTH != sbtc_pkg::COUNT_W) $error("count width must be sixteen");
	end

	logic [15:0] count;
	logic [15:0] next_count;
	logic [2:0]  prescale;
	logic [2:0]  next_prescale;
	logic [1:0]  instr_div;
	logic [1:0]  next_instr_div;
	logic        overflow_flag;
	logic        next_overflow_flag;
	logic        wake;
	logic        next_wake;
	logic        src_prev;
	logic        next_src_prev;
	logic        pre_prev;
	logic        next_pre_prev;
	sbtc_pkg::sbtc_arm_t arm;
	sbtc_pkg::sbtc_arm_t next_arm;
	logic        pin_sync;
	logic        xtal_sync;
	logic        gate_sync;
	logic        osc_run;
	logic        next_osc_run;

	// prescaler tap: bit n of counter is division 2^(n+1)
	function automatic logic prescale_tap(input logic [2:0] p, input logic [1:0] sel);
		logic r;
		r = 1'b0;
		case (sel)
			2'h1: r = p[0];
			2'h2: r = p[1];
			2'h3: r = p[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : prescale_tap

	// pins cross into the system clock domain before any logic reads them
	sbtc_sync #(.WIDTH(3)) u_pin_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_external_clock_pin, i_crystal_input_pin, i_gate_pin}),
		.o_sync  ({pin_sync, xtal_sync, gate_sync})
	);

	logic ext_sel;
	logic ext_level;
	logic counter_mode;
	logic gate_ok;
	logic enabled;
	logic any_write;
	logic raw_tick;
	logic count_tick;
	logic tap;

	// source selection and enable decode
	always_comb begin
		ext_sel = (i_clock_select_field == sbtc_pkg::CS_EXTERNAL);
		ext_level = i_oscillator_enable_bit ? xtal_sync : pin_sync;
		counter_mode = ext_sel;
		gate_ok = !i_gate_enable_bit || (gate_sync == i_gate_polarity_bit);
		enabled = i_run_bit && gate_ok;
		any_write = i_count_high_byte_we || i_count_low_byte_we;
		// async mode is modelled through the same sync path; only sleep counting and overflow wake differ
		case (i_clock_select_field)
			sbtc_pkg::CS_INSTR: raw_tick = (instr_div == sbtc_pkg::INSTR_DIV_LAST);
			sbtc_pkg::CS_SYSTEM: raw_tick = 1'b1;
			sbtc_pkg::CS_EXTERNAL: raw_tick = ext_level && !src_prev
				&& (arm == sbtc_pkg::SBTC_ARM_READY);
			default: raw_tick = 1'b0; // reserved selection never counts
		endcase
		if (i_sleep && !(ext_sel && i_sync_disable_bit)) begin
			raw_tick = 1'b0;
		end
	end

	// prescaler: count raw ticks, pass a tick on the chosen tap's rising edge
	always_comb begin
		next_prescale = prescale;
		if (enabled && raw_tick) next_prescale = prescale + 3'h1;
		if (any_write) next_prescale = sbtc_pkg::PRESCALE_RESET;
		tap = prescale_tap(next_prescale, i_prescale_field);
		if (i_prescale_field == 2'h0) begin
			count_tick = enabled && raw_tick && !any_write;
		end else begin
			// tied to a real source tick so a prescale field change cannot fake an edge
			count_tick = enabled && raw_tick && tap && !pre_prev && !any_write;
		end
		next_pre_prev = tap;
		next_instr_div = instr_div + 2'h1;
		next_src_prev = ext_level;
	end

	// falling edge arming for counter mode
	always_comb begin
		next_arm = arm;
		case (arm)
			sbtc_pkg::SBTC_ARM_IDLE:
				if (i_run_bit && counter_mode) next_arm = sbtc_pkg::SBTC_ARM_WAIT_LOW;
			sbtc_pkg::SBTC_ARM_WAIT_LOW:
				if (src_prev && !ext_level) next_arm = sbtc_pkg::SBTC_ARM_READY;
			sbtc_pkg::SBTC_ARM_READY: ;
			default: next_arm = sbtc_pkg::SBTC_ARM_IDLE;
		endcase
		if (!i_run_bit || !counter_mode || any_write) begin
			next_arm = sbtc_pkg::SBTC_ARM_IDLE;
		end
	end

	// counter, overflow flag and wake
	always_comb begin
		next_count = count;
		next_overflow_flag = overflow_flag;
		next_wake = 1'b0;
		if (i_overflow_clear) next_overflow_flag = 1'b0;
		if (count_tick) begin
			next_count = count + 16'h0001;
			if (count == sbtc_pkg::COUNT_ALL_ONES) begin
				next_overflow_flag = 1'b1;
				next_wake = ext_sel && i_sync_disable_bit;
			end
		end
		if (i_count_high_byte_we) next_count[15:8] = i_write_data;
		if (i_count_low_byte_we) next_count[7:0] = i_write_data;
		next_osc_run = i_oscillator_enable_bit;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			count <= sbtc_pkg::COUNT_RESET;
			prescale <= sbtc_pkg::PRESCALE_RESET;
			instr_div <= 2'h0;
			overflow_flag <= 1'b0;
			wake <= 1'b0;
			src_prev <= 1'b0;
			pre_prev <= 1'b0;
			arm <= sbtc_pkg::SBTC_ARM_IDLE;
			osc_run <= 1'b0;
		end else begin
			count <= next_count;
			prescale <= next_prescale;
			instr_div <= next_instr_div;
			overflow_flag <= next_overflow_flag;
			wake <= next_wake;
			src_prev <= next_src_prev;
			pre_prev <= next_pre_prev;
			arm <= next_arm;
			osc_run <= next_osc_run;
		end
	end

	// outputs; crystal drive is the inverted synchronised input while the registered enable is set
	assign o_count_high_byte = count[15:8];
	assign o_count_low_byte = count[7:0];
	assign o_time_base = count;
	assign o_overflow_flag = overflow_flag;
	assign o_wake = wake;
	assign o_oscillator_running = osc_run;
	assign o_crystal_output_pin = osc_run & ~xtal_sync;

	property p_wrap;
		@(posedge i_clk) disable iff (i_reset)
		(count_tick && count == sbtc_pkg::COUNT_ALL_ONES && !any_write)
			|=> (count == 16'h0000 && overflow_flag);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap failed");

	property p_off;
		@(posedge i_clk) disable iff (i_reset)
		(!i_run_bit && !any_write) |=> $stable(count);
	endproperty
	a_off: assert property (p_off) else $error("counted while off");

	property p_write_clears_prescale;
		@(posedge i_clk) disable iff (i_reset)
		any_write |=> (prescale == 3'h0);
	endproperty
	a_write_clears_prescale: assert property (p_write_clears_prescale) else $error("prescale kept");

	property p_low_write;
		@(posedge i_clk) disable iff (i_reset)
		(i_count_low_byte_we) |=> (count[7:0] == $past(i_write_data));
	endproperty
	a_low_write: assert property (p_low_write) else $error("low byte write lost");

	property p_gate_hold;
		@(posedge i_clk) disable iff (i_reset)
		(i_gate_enable_bit && gate_sync != i_gate_polarity_bit && !any_write) |=> $stable(count);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("counted with gate closed");

	property p_flag_sticky;
		@(posedge i_clk) disable iff (i_reset)
		(overflow_flag && !i_overflow_clear) |=> overflow_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

	property p_wake_async;
		@(posedge i_clk) disable iff (i_reset)
		wake |-> overflow_flag;
	endproperty
	a_wake_async: assert property (p_wake_async) else $error("wake without overflow");

	property p_arm;
		@(posedge i_clk) disable iff (i_reset)
		(ext_sel && arm != sbtc_pkg::SBTC_ARM_READY && !any_write) |=> $stable(count);
	endproperty
	a_arm: assert property (p_arm) else $error("counted before falling edge");

	// a byte write restarts the falling edge hunt in counter mode
	sequence s_byte_write;
		any_write;
	endsequence
	sequence s_disarmed;
		arm == sbtc_pkg::SBTC_ARM_IDLE;
	endsequence
	property p_write_disarms;
		@(posedge i_clk) disable iff (i_reset)
		s_byte_write |=> s_disarmed;
	endproperty
	a_write_disarms: assert property (p_write_disarms) else $error("still armed");

	property p_reserved;
		@(posedge i_clk) disable iff (i_reset)
		(i_clock_select_field == sbtc_pkg::CS_RESERVED && !any_write) |=> $stable(count);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved source counted");
endmodule : sbtc_timer

// *** tb/sbtc_ext_model.sv ***
// partner model: external clock pin, gate pin and crystal
`timescale 1ns/1ns
module sbtc_ext_model (
	input  wire logic i_clk,
	input  wire logic i_osc_run,
	output logic      o_ext_clk,
	output logic      o_crystal,
	output logic      o_gate
);
	// crystal swings only while powered, phase unrelated to the system clock
	initial begin
		o_crystal = 1'b0;
		forever #37 o_crystal = i_osc_run ? ~o_crystal : 1'b0;
	end
	// levels are set by the bench, which holds each one for several clocks
	task automatic pin_level(input logic lvl);
		o_ext_clk = lvl;
	endtask : pin_level
	task automatic set_gate(input logic lvl);
		o_gate = lvl;
	endtask : set_gate
	initial begin
		o_ext_clk = 1'b1;
		o_gate = 1'b0;
	end
endmodule : sbtc_ext_model

// *** tb/testbench.sv ***
// self-checking bench for the sixteen bit timer counter
`timescale 1ns/1ns
module testbench;
	logic        i_clk, i_reset, run, gen, gpol, osc, sdis, slp, hwe, lwe, oclr;
	logic [1:0]  csel, psc;
	logic [7:0]  wdata, hi, lo;
	logic [15:0] tbase, d;
	logic        flag, wake, orun, xout, seen;
	wire  logic  ext, xtal, gate;
	int          failures, total_checks;
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	sbtc_timer DUT (.i_clk(i_clk), .i_reset(i_reset), .i_run_bit(run),
		.i_gate_enable_bit(gen), .i_gate_polarity_bit(gpol), .i_clock_select_field(csel),
		.i_oscillator_enable_bit(osc), .i_prescale_field(psc), .i_sync_disable_bit(sdis),
		.i_sleep(slp), .i_count_high_byte_we(hwe), .i_count_low_byte_we(lwe),
		.i_write_data(wdata), .i_overflow_clear(oclr), .i_external_clock_pin(ext),
		.i_crystal_input_pin(xtal), .i_gate_pin(gate), .o_crystal_output_pin(xout),
		.o_count_high_byte(hi), .o_count_low_byte(lo), .o_time_base(tbase),
		.o_overflow_flag(flag), .o_wake(wake), .o_oscillator_running(orun));
	sbtc_ext_model ext_model (.i_clk(i_clk), .i_osc_run(orun), .o_ext_clk(ext),
		.o_crystal(xtal), .o_gate(gate));
	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t seen %h expected %h", $time, got, exp);
		end
	endtask : chk
	// inputs always move 1 ns after the edge so sampling never races
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	// one shared data bus, so the two bytes go in on separate cycles
	task automatic wr16(input logic [15:0] v);
		hwe = 1'b1;
		wdata = v[15:8];
		cyc(1);
		hwe = 1'b0;
		lwe = 1'b1;
		wdata = v[7:0];
		cyc(1);
		lwe = 1'b0;
		cyc(1);
	endtask : wr16
	task automatic rate(input int n);
		logic [15:0] a;
		a = tbase;
		cyc(n);
		d = tbase - a;
	endtask : rate
	task automatic t_reset();
		chk({hi, lo}, 16'h0000);
		chk({12'h0, flag, wake, orun, xout}, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_write();
		wr16(16'h55aa);
		chk({hi, lo}, 16'h55aa);
		chk(tbase, 16'h55aa);
		$display("test write done");
	endtask : t_write
	// 32 cycles hold a whole number of ticks for the instruction and system sources at every prescale
	task automatic t_rates();
		run = 1'b1;
		for (int s = 0; s < 2; s++)
			for (int p = 0; p < 4; p++) begin
				csel = s[1:0];
				psc = p[1:0];
				cyc(4);
				rate(32);
				chk(d, (16'd32 >> p) >> (s == 0 ? 2 : 0));
			end
		psc = 2'h0;
		csel = 2'h3;
		cyc(4);
		rate(32);
		chk(d, 16'h0000);
		csel = 2'h1;
		run = 1'b0;
		cyc(4);
		rate(32);
		chk(d, 16'h0000);
		$display("test rates done");
	endtask : t_rates
	task automatic t_gate();
		run = 1'b1;
		csel = 2'h1;
		gen = 1'b1;
		for (int k = 0; k < 4; k++) begin
			gpol = k[0];
			ext_model.set_gate(k[1]);
			cyc(6);
			rate(16);
			chk(d, (k[0] == k[1]) ? 16'd16 : 16'd0);
		end
		gen = 1'b0;
		cyc(4);
		rate(16);
		chk(d, 16'd16);
		run = 1'b0;
		$display("test gate done");
	endtask : t_gate
	task automatic t_overflow();
		wr16(16'hfffc);
		run = 1'b1;
		cyc(8);
		run = 1'b0;
		cyc(20);
		chk({15'h0, flag}, 16'h0001);
		chk({15'h0, ({hi, lo} < 16'h0010)}, 16'h0001);
		oclr = 1'b1;
		cyc(1);
		oclr = 1'b0;
		cyc(2);
		chk({15'h0, flag}, 16'h0000);
		$display("test overflow done");
	endtask : t_overflow
	// a rise straight after the write must be ignored until a fall is seen
	task automatic t_counter();
		csel = 2'h2;
		ext_model.pin_level(1'b0);
		cyc(6);
		wr16(16'h0000);
		run = 1'b1;
		for (int k = 0; k < 5; k++) begin
			ext_model.pin_level(k[0] ? 1'b0 : 1'b1);
			cyc(8);
		end
		chk({hi, lo}, 16'h0002);
		wr16(16'hffff);
		sdis = 1'b1;
		slp = 1'b1;
		ext_model.pin_level(1'b0);
		cyc(8);
		ext_model.pin_level(1'b1);
		seen = 1'b0;
		for (int k = 0; k < 20; k++) begin
			cyc(1);
			seen = seen | wake;
		end
		chk({15'h0, seen}, 16'h0001);
		sdis = 1'b0;
		csel = 2'h1;
		cyc(4);
		rate(16);
		chk(d, 16'h0000);
		slp = 1'b0;
		run = 1'b0;
		$display("test counter done");
	endtask : t_counter
	// settle the oscillator: clear flag, preload fc00, wait for 1024 crystal ticks
	task automatic t_osc();
		csel = 2'h2;
		osc = 1'b1;
		cyc(6);
		chk({15'h0, orun}, 16'h0001);
		oclr = 1'b1;
		cyc(1);
		oclr = 1'b0;
		wr16(16'hfc00);
		run = 1'b1;
		seen = 1'b0;
		for (int k = 0; k < 20; k++) begin
			cyc(1);
			seen = seen | xout;
		end
		chk({15'h0, seen}, 16'h0001);
		cyc(200);
		chk({15'h0, tbase != 16'hfc00}, 16'h0001);
		for (int k = 0; k < 11000 && !flag; k++) cyc(1);
		chk({15'h0, flag}, 16'h0001);
		// reset in mid-run must clear count and flag even with the source live
		i_reset = 1'b1;
		cyc(2);
		chk({hi, lo}, 16'h0000);
		chk({14'h0, flag, orun}, 16'h0000);
		i_reset = 1'b0;
		cyc(2);
		chk(tbase, 16'h0000);
		run = 1'b0;
		$display("test oscillator done");
	endtask : t_osc
	// bound on the whole run
	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		stop_test();
	end
	initial begin
		{run, gen, gpol, osc, sdis, slp, hwe, lwe, oclr} = 9'h000;
		{csel, psc, wdata} = 12'h000;
		failures = 0;
		total_checks = 0;
		i_reset = 1'b1;
		cyc(6);
		i_reset = 1'b0;
		t_reset();
		t_write();
		t_rates();
		t_gate();
		t_overflow();
		t_counter();
		t_osc();
		stop_test();
	end
endmodule : testbench
